// [hdl/hps_defs.svh]
// Purpose: constants of the headphone offset servo
// Assumes: 8-bit register addresses, 16-bit register data
// Notes: left channel is index 1, right channel index 0
`ifndef HPS_DEFS_SVH
`define HPS_DEFS_SVH
`define HPS_ADDR_CTRL0 8'h54
`define HPS_ADDR_CTRL1 8'h55
`define HPS_ADDR_STORE 8'h57
`define HPS_ADDR_RB_L 8'h59
`define HPS_ADDR_RB_R 8'h5a
`define HPS_EN_LSB 0
`define HPS_DW_LSB 2
`define HPS_SER_LSB 8
`define HPS_SGL_LSB 12
`define HPS_CNT_LSB 5
`define HPS_CNT_MSB 11
`define HPS_PER_LSB 0
`define HPS_PER_MSB 3
`define HPS_CNT_RST 7'h2a
`define HPS_PER_RST 4'ha
`define HPS_EN_RST 2'h0
`define HPS_CORR_RST 8'h00
`define HPS_CORR_MAX 8'h7f
`define HPS_CORR_MIN 8'h80
`define HPS_BASE_TIME_US 256000
`define HPS_CLK_MHZ 125
`define HPS_BASE_CYCLES (`HPS_BASE_TIME_US * `HPS_CLK_MHZ)
`define HPS_MEAS_CYCLES 250
`endif

// [hdl/hps_pkg.sv]
// Purpose: types of the headphone offset servo
// Assumes: nothing
// Notes: none
package hps_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_MEAS = 2'h1,
        ST_ADJ = 2'h3
    } hps_state_e;
    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_SINGLE = 2'h1,
        OP_SERIES = 2'h2,
        OP_PERIODIC = 2'h3
    } hps_op_e;
    typedef struct packed {
        hps_state_e st;
        hps_op_e op;
        logic sgl_pend;
        logic per_pend;
        logic dw_pend;
        logic [7:0] ser_left;
        logic [15:0] tmr;
        logic [7:0] corr;
    } hps_chan_s;
endpackage : hps_pkg

// [hdl/hps_servo.sv]
// Purpose: active-mode offset servo control for the two headphone channels
// Assumes: register port behind the two-wire control interface, window comparators per channel
// Notes: index 1 is left, index 0 is right
`timescale 1ns/1ps
`include "hps_defs.svh"
module hps_servo #(
    parameter int BASE_CYCLES = `HPS_BASE_CYCLES,
    parameter int MEAS_CYCLES = `HPS_MEAS_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // analogue side
    input wire logic [1:0] cmp_high_in,
    input wire logic [1:0] cmp_low_in,
    output logic [7:0] left_correction_out,
    output logic [7:0] right_correction_out
);
    function automatic logic [7:0] hps_step(input logic [7:0] c, input logic hi, input logic lo);
        hps_step = c;
        if (hi && !lo && c != `HPS_CORR_MIN) begin
            hps_step = c - 8'h01;
        end else if (lo && !hi && c != `HPS_CORR_MAX) begin
            hps_step = c + 8'h01;
        end
    endfunction : hps_step

    hps_pkg::hps_chan_s ch_q [2];
    hps_pkg::hps_chan_s ch_d [2];
    logic [1:0] en_q, en_d;
    logic [6:0] cnt_q, cnt_d;
    logic [3:0] per_q, per_d;
    logic [7:0] store_q [2];
    logic [7:0] store_d [2];
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q;
    logic [24:0] pre_q, pre_d;
    logic [15:0] tcnt_q, tcnt_d;
    logic tick, per_evt, wr0, wr1, wr7;
    logic [1:0] sgl_busy, ser_busy;
    logic [3:0] cmp_s1_q, cmp_s2_q;

    // comparator pins come from the analogue domain
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cmp_s1_q <= 4'h0;
            cmp_s2_q <= 4'h0;
        end else begin
            cmp_s1_q <= {cmp_high_in, cmp_low_in};
            cmp_s2_q <= cmp_s1_q;
        end
    end

    // base tick of 0.256 s and periodic event
    always_comb begin
        pre_d = pre_q + 25'h1;
        tick = 1'b0;
        if (pre_q == 25'(BASE_CYCLES - 1)) begin
            pre_d = 25'h0;
            tick = 1'b1;
        end
        tcnt_d = tcnt_q;
        per_evt = 1'b0;
        // timer stays at zero while periodic updates are off
        if (per_q == 4'h0) begin
            tcnt_d = 16'h0;
        end else if (tick) begin
            if (tcnt_q == (16'h1 << per_q) - 16'h1) begin
                tcnt_d = 16'h0;
                per_evt = 1'b1;
            end else begin
                tcnt_d = tcnt_q + 16'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pre_q <= 25'h0;
            tcnt_q <= 16'h0;
        end else begin
            pre_q <= pre_d;
            tcnt_q <= tcnt_d;
        end
    end

    assign wr0 = reg_wr_in && reg_addr_in == `HPS_ADDR_CTRL0;
    assign wr1 = reg_wr_in && reg_addr_in == `HPS_ADDR_CTRL1;
    assign wr7 = reg_wr_in && reg_addr_in == `HPS_ADDR_STORE;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            sgl_busy[i] = ch_q[i].sgl_pend || ch_q[i].op == hps_pkg::OP_SINGLE;
            ser_busy[i] = ch_q[i].ser_left != 8'h0 || ch_q[i].op == hps_pkg::OP_SERIES;
        end
    end

    // registers, channel engines and read data
    always_comb begin
        en_d = en_q;
        cnt_d = cnt_q;
        per_d = per_q;
        store_d = store_q;
        ch_d = ch_q;
        if (wr0) begin
            en_d = reg_wdata_in[`HPS_EN_LSB +: 2];
        end
        if (wr1) begin
            cnt_d = reg_wdata_in[`HPS_CNT_MSB:`HPS_CNT_LSB];
            per_d = reg_wdata_in[`HPS_PER_MSB:`HPS_PER_LSB];
        end
        if (wr7) begin
            store_d[1] = reg_wdata_in[15:8];
            store_d[0] = reg_wdata_in[7:0];
        end
        for (int i = 0; i < 2; i++) begin
            if (!en_d[i]) begin
                ch_d[i].st = hps_pkg::ST_IDLE;
                ch_d[i].op = hps_pkg::OP_NONE;
                ch_d[i].sgl_pend = 1'b0;
                ch_d[i].per_pend = 1'b0;
                ch_d[i].dw_pend = 1'b0;
                ch_d[i].ser_left = 8'h0;
            end else begin
                unique case (ch_q[i].st)
                    hps_pkg::ST_IDLE: begin
                        ch_d[i].tmr = 16'h0;
                        if (ch_q[i].dw_pend) begin
                            ch_d[i].corr = store_q[i];
                            ch_d[i].dw_pend = 1'b0;
                        end else if (ch_q[i].sgl_pend) begin
                            ch_d[i].st = hps_pkg::ST_MEAS;
                            ch_d[i].op = hps_pkg::OP_SINGLE;
                            ch_d[i].sgl_pend = 1'b0;
                        end else if (ch_q[i].ser_left != 8'h0) begin
                            ch_d[i].st = hps_pkg::ST_MEAS;
                            ch_d[i].op = hps_pkg::OP_SERIES;
                            ch_d[i].ser_left = ch_q[i].ser_left - 8'h1;
                        end else if (ch_q[i].per_pend) begin
                            ch_d[i].st = hps_pkg::ST_MEAS;
                            ch_d[i].op = hps_pkg::OP_PERIODIC;
                            ch_d[i].per_pend = 1'b0;
                        end
                    end
                    hps_pkg::ST_MEAS: begin
                        ch_d[i].tmr = ch_q[i].tmr + 16'h1;
                        if (ch_q[i].tmr == 16'(MEAS_CYCLES - 1)) begin
                            ch_d[i].st = hps_pkg::ST_ADJ;
                        end
                    end
                    hps_pkg::ST_ADJ: begin
                        ch_d[i].corr = hps_step(ch_q[i].corr, cmp_s2_q[2 + i], cmp_s2_q[i]);
                        ch_d[i].st = hps_pkg::ST_IDLE;
                        ch_d[i].op = hps_pkg::OP_NONE;
                    end
                    default: begin
                        ch_d[i].st = hps_pkg::ST_IDLE;
                        ch_d[i].op = hps_pkg::OP_NONE;
                    end
                endcase
                // new requests win over the clear of the same cycle
                if (wr0 && reg_wdata_in[`HPS_SGL_LSB + i]) begin
                    ch_d[i].sgl_pend = 1'b1;
                end
                if (wr0 && reg_wdata_in[`HPS_DW_LSB + i]) begin
                    ch_d[i].dw_pend = 1'b1;
                end
                // a rewrite during a run reloads the full count
                if (wr0 && reg_wdata_in[`HPS_SER_LSB + i]) begin
                    ch_d[i].ser_left = 8'(cnt_d) + 8'h1;
                end
                if (per_evt) begin
                    ch_d[i].per_pend = 1'b1;
                end
            end
        end
        // read data is captured in the strobe cycle and held until the next read
        rdata_d = rdata_q;
        if (reg_rd_in) begin
            rdata_d = 16'h0;
            unique case (reg_addr_in)
                `HPS_ADDR_CTRL0: begin
                    rdata_d[`HPS_EN_LSB +: 2] = en_q;
                    rdata_d[`HPS_DW_LSB +: 2] = {ch_q[1].dw_pend, ch_q[0].dw_pend};
                    rdata_d[`HPS_SER_LSB +: 2] = ser_busy;
                    rdata_d[`HPS_SGL_LSB +: 2] = sgl_busy;
                end
                `HPS_ADDR_CTRL1: begin
                    rdata_d[`HPS_CNT_MSB:`HPS_CNT_LSB] = cnt_q;
                    rdata_d[`HPS_PER_MSB:`HPS_PER_LSB] = per_q;
                end
                `HPS_ADDR_STORE: rdata_d = {store_q[1], store_q[0]};
                `HPS_ADDR_RB_L: rdata_d[7:0] = ch_q[1].corr;
                `HPS_ADDR_RB_R: rdata_d[7:0] = ch_q[0].corr;
                default: rdata_d = 16'h0;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            en_q <= `HPS_EN_RST;
            cnt_q <= `HPS_CNT_RST;
            per_q <= `HPS_PER_RST;
            store_q <= '{default: `HPS_CORR_RST};
            ch_q <= '{default: '0};
            rdata_q <= 16'h0;
            rvalid_q <= 1'b0;
        end else begin
            en_q <= en_d;
            cnt_q <= cnt_d;
            per_q <= per_d;
            store_q <= store_d;
            ch_q <= ch_d;
            rdata_q <= rdata_d;
            rvalid_q <= reg_rd_in;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign reg_rvalid_out = rvalid_q;
    assign left_correction_out = ch_q[1].corr;
    assign right_correction_out = ch_q[0].corr;

    // checks hold only outside reset
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_PERIOD_OFF: assert property (per_q == 4'h0 |-> !per_evt)
        else $error("periodic event with period off");
    AST_CTRL1_RESET: assert property ($fell(rst_in) |-> cnt_q == 7'h2a && per_q == 4'ha)
        else $error("control 1 reset value wrong");
    AST_RVALID_PULSE: assert property (reg_rvalid_out == $past(reg_rd_in))
        else $error("read valid not one cycle after strobe");

    for (genvar g = 0; g < 2; g++) begin : g_ast
        AST_DISABLED_IDLE: assert property (!en_q[g] |-> ch_q[g].st == hps_pkg::ST_IDLE && !sgl_busy[g]
            && !ser_busy[g])
            else $error("disabled channel active");
        AST_ONE_STEP: assert property (ch_q[g].st == hps_pkg::ST_ADJ |=> ch_q[g].corr == $past(ch_q[g].corr)
            || ch_q[g].corr == $past(ch_q[g].corr) + 8'h1 || ch_q[g].corr == $past(ch_q[g].corr) - 8'h1)
            else $error("adjust moved more than one code");
        AST_MEAS_END: assert property (ch_q[g].st == hps_pkg::ST_MEAS && ch_q[g].tmr == 16'(MEAS_CYCLES - 1)
            && en_d[g] |=> ch_q[g].st == hps_pkg::ST_ADJ)
            else $error("measurement did not end on time");
        AST_SGL_BUSY: assert property (wr0 && reg_wdata_in[`HPS_SGL_LSB + g] && reg_wdata_in[g]
            |=> sgl_busy[g])
            else $error("single trigger not busy");
        AST_SGL_READ: assert property (reg_rd_in && reg_addr_in == `HPS_ADDR_CTRL0
            |=> reg_rvalid_out && reg_rdata_out[`HPS_SGL_LSB + g] == $past(sgl_busy[g]))
            else $error("single busy read wrong");
        AST_PERIOD_SCHED: assert property (per_evt && en_q[g] && !wr0
            |=> ch_q[g].per_pend || ch_q[g].op == hps_pkg::OP_PERIODIC)
            else $error("periodic event lost");
        AST_SER_LOAD: assert property (wr0 && reg_wdata_in[`HPS_SER_LSB + g] && reg_wdata_in[g]
            |=> ch_q[g].ser_left == 8'($past(cnt_q)) + 8'h1)
            else $error("series count wrong");
        AST_SER_FALL: assert property ($fell(ser_busy[g]) |-> $past(ch_q[g].st) == hps_pkg::ST_ADJ
            || !en_q[g])
            else $error("series ended early");
        AST_READBACK: assert property (reg_rd_in && reg_addr_in == (g ? `HPS_ADDR_RB_L : `HPS_ADDR_RB_R)
            |=> reg_rdata_out == {8'h00, $past(ch_q[g].corr)})
            else $error("readback wrong");
        AST_DIRECT: assert property (ch_q[g].st == hps_pkg::ST_IDLE && ch_q[g].dw_pend && en_d[g]
            |=> ch_q[g].corr == $past(store_q[g]))
            else $error("direct write not loaded");
        AST_SATURATE: assert property (ch_q[g].corr == `HPS_CORR_MAX |=> ch_q[g].corr != `HPS_CORR_MIN)
            else $error("correction wrapped");
        AST_SATURATE_LOW: assert property (ch_q[g].corr == `HPS_CORR_MIN
            |=> ch_q[g].corr != `HPS_CORR_MAX)
            else $error("correction wrapped low");
        AST_NO_OVERLAP: assert property (ch_q[g].st == hps_pkg::ST_MEAS && en_d[g]
            |=> ch_q[g].op == $past(ch_q[g].op))
            else $error("operations overlapped");
        COV_SINGLE: cover property (ch_q[g].op == hps_pkg::OP_SINGLE && ch_q[g].st == hps_pkg::ST_ADJ);
        COV_SERIES: cover property ($fell(ser_busy[g]) && en_q[g]);
        COV_PERIODIC: cover property (ch_q[g].op == hps_pkg::OP_PERIODIC && ch_q[g].st == hps_pkg::ST_ADJ);
        COV_DIRECT: cover property (ch_q[g].st == hps_pkg::ST_IDLE && ch_q[g].dw_pend && en_q[g]);
        COV_SATURATE: cover property (ch_q[g].st == hps_pkg::ST_ADJ && (ch_q[g].corr == `HPS_CORR_MAX
            || ch_q[g].corr == `HPS_CORR_MIN));
    end
endmodule : hps_servo

// [verif/hps_servo_tb.sv]
// Purpose: self-checking bench for the headphone offset servo register port
// Assumes: short base period and measurement time so every count fits a short run
// Notes: comparator high held on both channels until the last test switches to comparator low, so adjustments move down, then up
`timescale 1ns/1ps
`include "hps_defs.svh"
module hps_servo_tb;
    localparam int BASE = 20;
    localparam int MEAS = 4;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [15:0] reg_rdata_out;
    logic reg_rvalid_out;
    logic [1:0] cmp_high_in = 2'h0;
    logic [1:0] cmp_low_in = 2'h0;
    logic [7:0] left_correction_out;
    logic [7:0] right_correction_out;
    int num_errors = 0;
    int comparisons = 0;
    logic [15:0] v;
    logic [7:0] s;
    logic [7:0] p;
    int n;
    int k;

    hps_servo #(.BASE_CYCLES(BASE), .MEAS_CYCLES(MEAS)) uut (
        .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .reg_rvalid_out(reg_rvalid_out), .cmp_high_in(cmp_high_in), .cmp_low_in(cmp_low_in),
        .left_correction_out(left_correction_out), .right_correction_out(right_correction_out)
    );

    always #4 clk_in = ~clk_in;

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        #1;
        reg_wr_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(posedge clk_in);
        #1;
        reg_wr_in = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_in);
        #1;
        reg_rd_in = 1'b1;
        reg_addr_in = a;
        @(posedge clk_in);
        #1;
        reg_rd_in = 1'b0;
        check({15'h0, reg_rvalid_out}, 16'h0001);
        d = reg_rdata_out;
    endtask : rd

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        check(d, exp);
    endtask : rd_chk

    // polls control 0 until the busy bits in mask have all dropped
    task automatic wait_idle(input logic [15:0] mask);
        logic [15:0] d;
        int i;
        for (i = 0; i < 1000; i++) begin
            rd(`HPS_ADDR_CTRL0, d);
            if ((d & mask) == 16'h0) break;
        end
        if (i == 1000) begin
            num_errors++;
            $display("wrong value at %0t: busy bits never cleared", $time);
            tally_and_finish();
        end
    endtask : wait_idle

    // cycles until the left correction next changes
    task automatic gap(output int c);
        logic [7:0] q;
        q = left_correction_out;
        for (c = 1; c <= 400; c++) begin
            @(posedge clk_in);
            #1;
            if (left_correction_out !== q) break;
        end
        if (c > 400) begin
            num_errors++;
            $display("wrong value at %0t: no periodic update seen", $time);
            tally_and_finish();
        end
    endtask : gap

    initial begin
        repeat (10) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        cmp_high_in = 2'h3;
        rd_chk(`HPS_ADDR_CTRL0, 16'h0000);
        rd_chk(`HPS_ADDR_CTRL1, 16'h054a);
        rd_chk(`HPS_ADDR_RB_L, 16'h0000);
        rd_chk(`HPS_ADDR_RB_R, 16'h0000);
        rd_chk(8'h56, 16'h0000);
        wr(`HPS_ADDR_CTRL1, 16'h0040);
        rd_chk(`HPS_ADDR_CTRL1, 16'h0040);
        $display("test reset and config done");

        wr(`HPS_ADDR_CTRL0, 16'h2000);
        repeat (2 * MEAS + 8) @(posedge clk_in);
        #1;
        check({8'h0, left_correction_out}, 16'h0000);
        wr(`HPS_ADDR_CTRL0, 16'h2002);
        rd_chk(`HPS_ADDR_CTRL0, 16'h2002);
        wait_idle(16'h2000);
        rd_chk(`HPS_ADDR_CTRL0, 16'h0002);
        s = left_correction_out;
        check({15'h0, (s === 8'h01) || (s === 8'hff)}, 16'h0001);
        check({8'h0, right_correction_out}, 16'h0000);
        rd_chk(`HPS_ADDR_RB_L, {8'h0, s});
        $display("test single done");

        wr(`HPS_ADDR_CTRL0, 16'h0101);
        rd_chk(`HPS_ADDR_CTRL0, 16'h0101);
        wait_idle(16'h0100);
        check({8'h0, right_correction_out}, {8'h0, 8'(s + s + s)});
        rd_chk(`HPS_ADDR_RB_R, {8'h0, 8'(s + s + s)});
        check({8'h0, left_correction_out}, {8'h0, s});
        wr(`HPS_ADDR_CTRL1, 16'h0fe0);
        wr(`HPS_ADDR_CTRL0, 16'h0101);
        wait_idle(16'h0100);
        check({8'h0, right_correction_out}, (s == 8'h01) ? 16'h007f : 16'h0080);
        $display("test series and saturation done");

        wr(`HPS_ADDR_CTRL1, 16'h0000);
        wr(`HPS_ADDR_CTRL0, 16'h2202);
        wait_idle(16'h2200);
        check({8'h0, left_correction_out}, {8'h0, 8'(s + s + s)});
        $display("test single with series done");

        for (k = 1; k <= 2; k++) begin
            wr(`HPS_ADDR_CTRL1, 16'(k));
            gap(n);
            gap(n);
            check(16'(n), 16'(BASE << k));
        end
        wr(`HPS_ADDR_CTRL1, 16'h0000);
        repeat (2 * MEAS + 8) @(posedge clk_in);
        #1;
        p = left_correction_out;
        repeat (200) @(posedge clk_in);
        #1;
        check({8'h0, left_correction_out}, {8'h0, p});
        $display("test periodic done");

        rd(`HPS_ADDR_RB_L, v);
        wr(`HPS_ADDR_STORE, 16'ha53c);
        wr(`HPS_ADDR_CTRL0, 16'h000f);
        wait_idle(16'h000c);
        check({left_correction_out, right_correction_out}, 16'ha53c);
        wr(`HPS_ADDR_RB_L, 16'h0000);
        rd_chk(`HPS_ADDR_RB_L, 16'h00a5);
        rd_chk(`HPS_ADDR_RB_R, 16'h003c);
        wr(`HPS_ADDR_STORE, {v[7:0], 8'h3c});
        wr(`HPS_ADDR_CTRL0, 16'h000f);
        wait_idle(16'h000c);
        check({8'h0, left_correction_out}, {8'h0, v[7:0]});
        check({8'h0, v[7:0]}, {8'h0, p});
        $display("test direct write done");

        cmp_high_in = 2'h0;
        cmp_low_in = 2'h3;
        wr(`HPS_ADDR_CTRL1, 16'h0fe0);
        wr(`HPS_ADDR_CTRL0, 16'h0101);
        wait_idle(16'h0100);
        check({8'h0, right_correction_out}, 16'h007f);
        check({8'h0, left_correction_out}, {8'h0, v[7:0]});
        $display("test upward saturation done");
        tally_and_finish();
    end
endmodule : hps_servo_tb
